//--- verilog/crf_core.sv
// crf_core: cpu register file with flag word, alu flag update and avalon access
// assumes the datapath uses the core port; software/debug uses avalon
`timescale 1ns/100ps

module crf_core (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// core read port
	input  wire logic [3:0]  rdSel,
	input  wire logic [1:0]  rdSize,
	output logic [31:0]      rdData,
	// core write port
	input  wire logic        wrReq,
	input  wire logic [3:0]  wrSel,
	input  wire logic [1:0]  wrSize,
	input  wire logic [31:0] wrData,
	// program counter
	input  wire logic        pcLoad,
	input  wire logic [19:0] pcNext,
	// alu flag update
	input  wire logic        aluFlagEn,
	input  wire logic        aluCarry,
	input  wire logic        aluZero,
	input  wire logic        aluSign,
	input  wire logic        aluOverflow,
	// interrupts
	input  wire logic        irqReq,
	input  wire logic [2:0]  irqLevel,
	input  wire logic        irqAck,
	input  wire logic        swiExec,
	input  wire logic [5:0]  swiNum,
	output logic             irqAccept,
	// state views
	output logic [15:0]      stackPointer,
	output logic [15:0]      frameBase,
	output logic [15:0]      staticBase,
	output logic [19:0]      vectorTableBase,
	output logic [19:0]      programCounter,
	output logic [10:0]      flagWord,
	// avalon-mm slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);
	// ****************************************
	// state
	// ****************************************
	logic [15:0]  userSp;
	logic [15:0]  intSp;
	logic [15:0]  sbReg;
	logic [19:0]  vtbReg;
	logic [19:0]  pcReg;
	logic [10:0]  processor_flag_word;
	logic [111:0] bank0;
	logic [111:0] bank1;
	logic         avDone;
	logic [31:0]  avRd;

	// ****************************************
	// flag fields
	// ****************************************
	wire       bankSel  = processor_flag_word[crf_pkg::FLG_BANK];
	wire       stackSel = processor_flag_word[crf_pkg::FLG_STACK];
	wire       intEn    = processor_flag_word[crf_pkg::FLG_IEN];
	wire [2:0] processor_priority_level      = processor_flag_word[crf_pkg::FLG_IPL +: 3];

	// selected bank view
	wire [111:0] bankCur = bankSel ? bank1 : bank0;
	wire [15:0] d0 = bankCur[15:0];
	wire [15:0] d1 = bankCur[31:16];
	wire [15:0] d2 = bankCur[47:32];
	wire [15:0] d3 = bankCur[63:48];
	wire [15:0] a0 = bankCur[79:64];
	wire [15:0] a1 = bankCur[95:80];
	wire [15:0] fb = bankCur[111:96];

	// active stack pointer
	wire [15:0] activeSp = stackSel ? userSp : intSp;

	// ****************************************
	// interrupt gate
	// ****************************************
	assign irqAccept = irqReq & intEn & (irqLevel > processor_priority_level);
	wire swiLow = swiExec & (swiNum <= 6'(crf_pkg::SWI_LOW_LIMIT));

	// ****************************************
	// avalon decode; waitrequest low one cycle after request
	// ****************************************
	wire avReq  = avs_read | avs_write;
	wire avWr   = avs_write & avDone;
	wire [1:0] avBe = avs_byteenable[1:0];
	// one hit per mapped offset
	wire hitD0  = avs_address == crf_pkg::OFS_D0;
	wire hitD1  = avs_address == crf_pkg::OFS_D1;
	wire hitD2  = avs_address == crf_pkg::OFS_D2;
	wire hitD3  = avs_address == crf_pkg::OFS_D3;
	wire hitA0  = avs_address == crf_pkg::OFS_A0;
	wire hitA1  = avs_address == crf_pkg::OFS_A1;
	wire hitFb  = avs_address == crf_pkg::OFS_FB;
	wire hitUsp = avs_address == crf_pkg::OFS_USP;
	wire hitIsp = avs_address == crf_pkg::OFS_ISP;
	wire hitSb  = avs_address == crf_pkg::OFS_SB;
	wire hitVtb = avs_address == crf_pkg::OFS_VTB;
	wire hitPc  = avs_address == crf_pkg::OFS_PC;
	wire hitFlg = avs_address == crf_pkg::OFS_FLG;
	// wait only in the first cycle of a request
	assign avs_waitrequest = avReq & ~avDone;

	// ****************************************
	// core write decode
	// ****************************************
	wire cw      = wrReq;
	wire szPair  = wrSize == crf_pkg::SZ_PAIR;
	wire [1:0] cBe = (wrSize == crf_pkg::SZ_LOW)  ? 2'h1 :
		(wrSize == crf_pkg::SZ_HIGH) ? 2'h2 : 2'h3;
	// write strobes per register select
	wire cwD0  = cw & (wrSel == crf_pkg::SEL_D0);
	wire cwD1  = cw & (wrSel == crf_pkg::SEL_D1);
	wire cwD2  = cw & ((wrSel == crf_pkg::SEL_D2) | (cwD0 & szPair));
	wire cwD3  = cw & ((wrSel == crf_pkg::SEL_D3) | (cwD1 & szPair));
	wire cwA0  = cw & (wrSel == crf_pkg::SEL_A0);
	wire cwA1  = cw & ((wrSel == crf_pkg::SEL_A1) | (cwA0 & szPair));
	wire cwFb  = cw & (wrSel == crf_pkg::SEL_FB);
	wire cwSp  = cw & (wrSel == crf_pkg::SEL_SP);
	wire cwUsp = cw & (wrSel == crf_pkg::SEL_USP);
	wire cwIsp = cw & (wrSel == crf_pkg::SEL_ISP);
	wire cwSb  = cw & (wrSel == crf_pkg::SEL_SB);
	wire cwVtb = cw & (wrSel == crf_pkg::SEL_VTB);
	wire cwPc  = cw & (wrSel == crf_pkg::SEL_PC);
	wire cwFlg = cw & (wrSel == crf_pkg::SEL_FLG);

	// bank write: core has priority over the bus in the same cycle
	wire [6:0] bankWrCore = {cwFb, cwA1, cwA0, cwD3, cwD2, cwD1, cwD0};
	wire [6:0] bankWrBus  = {7{avWr & ~cw}} &
		{hitFb, hitA1, hitA0, hitD3, hitD2, hitD1, hitD0};
	wire [6:0] bankWr     = bankWrCore | bankWrBus;
	// upper word of a pair goes to d2/d3/a1
	wire [6:0] hiWord     = {1'b0, cwA0 & szPair, 1'b0,
		cwD1 & szPair, cwD0 & szPair, 2'h0};
	wire [15:0] cLowData  = (wrSize == crf_pkg::SZ_HIGH) ?
		{wrData[7:0], 8'h00} : wrData[15:0];
	wire [15:0] bankData  = cw ? cLowData : avs_writedata[15:0];
	wire [1:0]  bankBe    = cw ? cBe : avBe;
	wire [6:0]  wr0       = bankSel ? 7'h00 : bankWr;
	wire [6:0]  wr1       = bankSel ? bankWr : 7'h00;

	// ****************************************
	// two banks
	// ****************************************
	// low halves share one instance path; pair upper words need own data
	logic [15:0] pairHi;
	assign pairHi = wrData[31:16];
	wire [6:0] lowWr0 = wr0 & ~hiWord;
	wire [6:0] lowWr1 = wr1 & ~hiWord;
	logic [111:0] b0Lo;
	logic [111:0] b1Lo;

	// ****************************************
	// per-register write data
	// ****************************************
	// pair writes put the upper half of wrData into the upper register only
	logic [111:0] bankWrData;
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : gWrData
			assign bankWrData[gi*16 +: 16] = hiWord[gi] ? pairHi : bankData;
		end
	endgenerate

	crf_bank #(.W(16)) uBank0 (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.wrEn    (lowWr0 | (wr0 & hiWord)),
		.byteEn  (bankBe),
		.wrData  (bankWrData),
		.regs    (b0Lo)
	);
	crf_bank #(.W(16)) uBank1 (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.wrEn    (lowWr1 | (wr1 & hiWord)),
		.byteEn  (bankBe),
		.wrData  (bankWrData),
		.regs    (b1Lo)
	);
	assign bank0 = b0Lo;
	assign bank1 = b1Lo;

	// ****************************************
	// next flag word
	// ****************************************
	logic [10:0] next_flg;
	always_comb begin
		next_flg = processor_flag_word;
		if (cwFlg)
			next_flg = wrData[10:0];
		else if (avWr & hitFlg)
			next_flg = avs_writedata[10:0];
		if (aluFlagEn) begin
			next_flg[crf_pkg::FLG_CARRY] = aluCarry;
			next_flg[crf_pkg::FLG_ZERO]  = aluZero;
			next_flg[crf_pkg::FLG_SIGN]  = aluSign;
			next_flg[crf_pkg::FLG_OVF]   = aluOverflow;
		end
		if (irqAck)
			next_flg[crf_pkg::FLG_IEN] = 1'b0;
		if (irqAck | swiLow)
			next_flg[crf_pkg::FLG_STACK] = 1'b0;
	end

	// flag word register, 11 bits
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			processor_flag_word <= crf_pkg::FLAG_RST;
		end else begin
			processor_flag_word <= next_flg;
		end
	end

	// ****************************************
	// stack pointers, static base, vector base
	// ****************************************
	wire wUsp = cwUsp | (cwSp & stackSel) | (avWr & ~cw & hitUsp);
	wire wIsp = cwIsp | (cwSp & ~stackSel) | (avWr & ~cw & hitIsp);
	wire [15:0] spData = cw ? wrData[15:0] : avs_writedata[15:0];
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			userSp <= crf_pkg::WORD_RST;
			intSp  <= crf_pkg::WORD_RST;
		end else begin
			if (wUsp) userSp <= spData;
			if (wIsp) intSp  <= spData;
		end
	end

	// static base and vector base
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sbReg  <= crf_pkg::WORD_RST;
			vtbReg <= crf_pkg::ADDR_RST;
		end else begin
			if (cwSb)
				sbReg <= wrData[15:0];
			else if (avWr & hitSb)
				sbReg <= avs_writedata[15:0];
			if (cwVtb)
				vtbReg <= wrData[19:0];
			else if (avWr & hitVtb)
				vtbReg <= avs_writedata[19:0];
		end
	end

	// program counter: load wins, then register write
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pcReg <= crf_pkg::ADDR_RST;
		end else if (pcLoad) begin
			pcReg <= pcNext;
		end else if (cwPc) begin
			pcReg <= wrData[19:0];
		end else if (avWr & hitPc) begin
			pcReg <= avs_writedata[19:0];
		end
	end

	// ****************************************
	// core read mux
	// ****************************************
	logic [15:0] rdWord;
	logic [15:0] rdUpper;
	always_comb begin
		rdUpper = 16'h0000;
		case (rdSel)
			crf_pkg::SEL_D0: begin
				rdWord  = d0;
				rdUpper = d2;
			end
			crf_pkg::SEL_D1: begin
				rdWord  = d1;
				rdUpper = d3;
			end
			crf_pkg::SEL_D2:  rdWord = d2;
			crf_pkg::SEL_D3:  rdWord = d3;
			crf_pkg::SEL_A0: begin
				rdWord  = a0;
				rdUpper = a1;
			end
			crf_pkg::SEL_A1:  rdWord = a1;
			crf_pkg::SEL_FB:  rdWord = fb;
			crf_pkg::SEL_SP:  rdWord = activeSp;
			crf_pkg::SEL_USP: rdWord = userSp;
			crf_pkg::SEL_ISP: rdWord = intSp;
			crf_pkg::SEL_SB:  rdWord = sbReg;
			crf_pkg::SEL_VTB: begin
				rdWord  = vtbReg[15:0];
				rdUpper = {12'h000, vtbReg[19:16]};
			end
			crf_pkg::SEL_PC: begin
				rdWord  = pcReg[15:0];
				rdUpper = {12'h000, pcReg[19:16]};
			end
			crf_pkg::SEL_FLG: rdWord = {5'h00, processor_flag_word};
			default:          rdWord = 16'h0000;
		endcase
	end
	// byte and pair views of the word read
	assign rdData = (rdSize == crf_pkg::SZ_LOW)  ? {24'h000000, rdWord[7:0]} :
		(rdSize == crf_pkg::SZ_HIGH) ? {24'h000000, rdWord[15:8]} :
		(rdSize == crf_pkg::SZ_PAIR) ? {rdUpper, rdWord} : {16'h0000, rdWord};

	// ****************************************
	// avalon read mux
	// ****************************************
	assign avRd =
		hitD0  ? {16'h0000, d0} : hitD1  ? {16'h0000, d1} :
		hitD2  ? {16'h0000, d2} : hitD3  ? {16'h0000, d3} :
		hitA0  ? {16'h0000, a0} : hitA1  ? {16'h0000, a1} :
		hitFb  ? {16'h0000, fb} : hitUsp ? {16'h0000, userSp} :
		hitIsp ? {16'h0000, intSp} : hitSb ? {16'h0000, sbReg} :
		hitVtb ? {12'h000, vtbReg} : hitPc ? {12'h000, pcReg} :
		hitFlg ? {21'h000000, processor_flag_word} : crf_pkg::UNMAPPED_RD;

	// one wait state per request, read data registered
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			avDone       <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			avDone <= avReq & ~avDone;
			if (avs_read & ~avDone) avs_readdata <= avRd;
		end
	end

	// ****************************************
	// state outputs
	// ****************************************
	assign stackPointer    = activeSp;
	assign frameBase       = fb;
	assign staticBase      = sbReg;
	assign vectorTableBase = vtbReg;
	assign programCounter  = pcReg;
	assign flagWord        = processor_flag_word;
endmodule : crf_core

//--- pkg/crf_pkg.sv
// crf_pkg: constants for the cpu register file and flag word
// assumes a single core clock; offsets are avalon word byte addresses
//
// Summary of operation
// - thirteen registers; data, address and frame base form one bank, two banks.
// - data registers are 16 bits; data zero and one split into bytes.
// - data two above data zero and three above one give 32-bit views.
// - address registers are 16 bits; second above first gives 32 bits.
// - frame base is 16 bits and bases frame-relative addressing.
// - vector table base is 20 bits, start of the interrupt vector table.
// - program counter is 20 bits, address of next instruction.
// - user and interrupt stack pointers are 16 bits each.
// - stack select 0 picks interrupt stack, 1 picks user stack.
// - hardware acknowledge or software interrupt 0..31 forces stack select to 0.
// - static base is 16 bits and bases static-relative addressing.
// - flag word is 11 bits and shows cpu state.
// - carry flag takes carry, borrow or shifted-out bit from the alu.
// - zero flag is 1 when a result is zero, else 0.
// - sign flag is 1 when a result is negative, else 0.
// - bank select 0 picks bank 0, 1 picks bank 1, all banked together.
// - overflow flag is 1 on overflow, else 0.
// - maskable interrupts blocked while enable flag is 0, allowed at 1.
// - interrupt acknowledge clears the interrupt enable flag.
// - priority level is 3 bits; accept only a request above it.
// - reserved flag bit written 0; its read value is undefined.

package crf_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int WORD_W = 16;
	localparam int ADDR_W = 20;
	localparam int FLAG_W = 11;
	localparam int IPL_W  = 3;
	localparam int BANK_N = 2;
	localparam int SWI_LOW_LIMIT = 31;

	// ****************************************
	// flag word bit positions
	// ****************************************
	localparam int FLG_CARRY = 0;
	localparam int FLG_DEBUG = 1;
	localparam int FLG_ZERO  = 2;
	localparam int FLG_SIGN  = 3;
	localparam int FLG_BANK  = 4;
	localparam int FLG_OVF   = 5;
	localparam int FLG_IEN   = 6;
	localparam int FLG_STACK = 7;
	localparam int FLG_IPL   = 8;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [10:0] FLAG_RST = 11'h000;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [19:0] ADDR_RST = 20'h00000;

	// ****************************************
	// register selector for the core port
	// ****************************************
	typedef enum logic [3:0] {
		SEL_D0 = 4'h0, SEL_D1 = 4'h1, SEL_D2 = 4'h2, SEL_D3 = 4'h3,
		SEL_A0 = 4'h4, SEL_A1 = 4'h5, SEL_FB = 4'h6, SEL_SP = 4'h7,
		SEL_USP = 4'h8, SEL_ISP = 4'h9, SEL_SB = 4'ha, SEL_VTB = 4'hb,
		SEL_PC = 4'hc, SEL_FLG = 4'hd
	} crf_sel_t;

	// core access sizes
	typedef enum logic [1:0] {
		SZ_WORD = 2'h0, SZ_LOW = 2'h1, SZ_HIGH = 2'h2, SZ_PAIR = 2'h3
	} crf_size_t;

	// ****************************************
	// avalon offsets (byte addresses)
	// ****************************************
	localparam logic [5:0] OFS_D0  = 6'h00;
	localparam logic [5:0] OFS_D1  = 6'h04;
	localparam logic [5:0] OFS_D2  = 6'h08;
	localparam logic [5:0] OFS_D3  = 6'h0c;
	localparam logic [5:0] OFS_A0  = 6'h10;
	localparam logic [5:0] OFS_A1  = 6'h14;
	localparam logic [5:0] OFS_FB  = 6'h18;
	localparam logic [5:0] OFS_USP = 6'h1c;
	localparam logic [5:0] OFS_ISP = 6'h20;
	localparam logic [5:0] OFS_SB  = 6'h24;
	localparam logic [5:0] OFS_VTB = 6'h28;
	localparam logic [5:0] OFS_PC  = 6'h2c;
	localparam logic [5:0] OFS_FLG = 6'h30;
	localparam logic [5:0] OFS_PEND = 6'h34;
	localparam logic [31:0] UNMAPPED_RD = 32'h00000000;
endpackage : crf_pkg

//--- verilog/crf_bank.sv
// crf_bank: one bank of data, address and frame base registers
// assumes the parent steers writes to the selected bank only
`timescale 1ns/100ps

module crf_bank #(
	parameter int W = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic [6:0]   wrEn,
	input  wire logic [1:0]   byteEn,
	input  wire logic [7*W-1:0] wrData,
	output logic [7*W-1:0]    regs
);
	// ****************************************
	// storage: d0 d1 d2 d3 a0 a1 fb
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : gReg
			logic [W-1:0] r;
			// byte-lane write keeps the other half
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n)
					r <= W'(crf_pkg::WORD_RST);
				else if (wrEn[g]) begin
					if (byteEn[0]) r[W/2-1:0] <= wrData[g*W +: W/2];
					if (byteEn[1]) r[W-1:W/2] <= wrData[g*W+W/2 +: W/2];
				end
			end
			assign regs[g*W +: W] = r;
		end
	endgenerate
endmodule : crf_bank

//--- tb/crf_core_properties.sv
// crf_core_properties: port-level checks on crf_core
// assumes one clock clk_sys and async active-low reset_n
`timescale 1ns/100ps

module crf_core_properties (
	input logic        clk_sys,
	input logic        reset_n,
	input logic        pcLoad,
	input logic [19:0] pcNext,
	input logic        aluFlagEn,
	input logic        aluCarry,
	input logic        aluZero,
	input logic        aluSign,
	input logic        aluOverflow,
	input logic        irqReq,
	input logic [2:0]  irqLevel,
	input logic        irqAck,
	input logic        swiExec,
	input logic [5:0]  swiNum,
	input logic        irqAccept,
	input logic [19:0] programCounter,
	input logic [10:0] flagWord,
	input logic        avs_read,
	input logic        avs_write,
	input logic        avs_waitrequest
);
	// ****************************************
	// assertions
	// ****************************************
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	ack_clears_ien_a: assert property (irqAck |=> !flagWord[crf_pkg::FLG_IEN])
		else $error("enable flag kept after acknowledge");
	ack_isp_select_a: assert property (irqAck |=> !flagWord[crf_pkg::FLG_STACK])
		else $error("stack select kept after acknowledge");
	swi_isp_select_a: assert property (swiExec && swiNum <= 6'd31 |=> !flagWord[7])
		else $error("stack select kept after low software interrupt");
	irq_accept_gate_a: assert property (irqAccept == (irqReq && flagWord[6]
		&& irqLevel > flagWord[crf_pkg::FLG_IPL +: 3]))
		else $error("interrupt accept gating wrong");
	alu_flag_copy_a: assert property (aluFlagEn |=>
		{flagWord[5], flagWord[3], flagWord[2], flagWord[0]}
		== $past({aluOverflow, aluSign, aluZero, aluCarry}))
		else $error("alu flags not captured");
	pc_load_a: assert property (pcLoad |=> programCounter == $past(pcNext))
		else $error("program counter not loaded");
	reset_values_a: assert property ($rose(reset_n) |-> flagWord == 11'h000)
		else $error("flag word not cleared by reset");
	bus_one_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	bus_idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high while idle");

	// main scenarios reached
	cover property (irqAccept);
	cover property (avs_read && !avs_waitrequest);
	cover property (swiExec && swiNum <= 6'd31);
endmodule : crf_core_properties

bind crf_core crf_core_properties i_crf_core_properties (.clk_sys, .reset_n, .pcLoad,
	.pcNext, .aluFlagEn, .aluCarry, .aluZero, .aluSign, .aluOverflow, .irqReq, .irqLevel,
	.irqAck, .swiExec, .swiNum, .irqAccept, .programCounter, .flagWord, .avs_read,
	.avs_write, .avs_waitrequest);

//--- tb/crf_dp_model.sv
// crf_dp_model: datapath side of the register file, driven by tasks
// assumes the bench calls one task at a time; each ends at a falling edge
`timescale 1ns/100ps

module crf_dp_model (
	input  logic        clk_sys,
	input  logic [31:0] rdData,
	output logic [3:0]  rdSel,
	output logic [1:0]  rdSize,
	output logic        wrReq,
	output logic [3:0]  wrSel,
	output logic [1:0]  wrSize,
	output logic [31:0] wrData,
	output logic        pcLoad,
	output logic [19:0] pcNext,
	output logic        aluFlagEn,
	output logic [3:0]  aluBits,
	output logic        irqReq,
	output logic [2:0]  irqLevel,
	output logic        irqAck,
	output logic        swiExec,
	output logic [5:0]  swiNum
);
	// ****************************************
	// core side tasks
	// ****************************************
	initial begin
		{rdSel, rdSize, wrReq, wrSel, wrSize, wrData, pcLoad, pcNext} = '0;
		{aluFlagEn, aluBits, irqReq, irqLevel, irqAck, swiExec, swiNum} = '0;
	end

	// write; debug flag bit 1 sent as zero on flag word writes, other bits as given
	task automatic coreWr(input logic [3:0] sel, input logic [1:0] size, input logic [31:0] d);
		@(posedge clk_sys);
		wrReq  <= 1'b1;
		wrSel  <= sel;
		wrSize <= size;
		wrData <= (sel == crf_pkg::SEL_FLG) ? (d & 32'hfffffffd) : d;
		@(posedge clk_sys);
		wrReq <= 1'b0;
		@(negedge clk_sys);
	endtask : coreWr

	task automatic coreRd(input logic [3:0] sel, input logic [1:0] size, output logic [31:0] q);
		@(posedge clk_sys);
		rdSel  <= sel;
		rdSize <= size;
		@(negedge clk_sys);
		q = rdData;
	endtask : coreRd

	// one-cycle strobe with its qualifiers; bits {c,z,s,o}
	task automatic strobe(input int kind, input logic [19:0] v);
		@(posedge clk_sys);
		case (kind)
			0: begin pcLoad <= 1'b1; pcNext <= v; end
			1: begin aluFlagEn <= 1'b1; aluBits <= v[3:0]; end
			2: irqAck <= 1'b1;
			default: begin swiExec <= 1'b1; swiNum <= v[5:0]; end
		endcase
		@(posedge clk_sys);
		{pcLoad, aluFlagEn, irqAck, swiExec} <= 4'h0;
		@(negedge clk_sys);
	endtask : strobe

	task automatic irqSet(input logic req, input logic [2:0] lvl);
		@(posedge clk_sys);
		irqReq   <= req;
		irqLevel <= lvl;
		@(negedge clk_sys);
	endtask : irqSet
endmodule : crf_dp_model

//--- tb/crf_core_tb.sv
// crf_core_tb: directed test of crf_core over avalon and the core port
// assumes crf_pkg, crf_core and crf_dp_model are compiled first
`timescale 1ns/100ps

module crf_core_tb;
	logic        clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, irqAccept;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdData, q, m;
	logic [15:0] stackPointer, frameBase, staticBase;
	logic [19:0] programCounter, vectorTableBase;
	logic [10:0] flagWord;
	int          num_errors, checks, cycles;

	// ****************************************
	// design, datapath model, clock
	// ****************************************
	crf_dp_model i_crf_dp_model (.clk_sys(clk_sys), .rdData(rdData), .rdSel(), .rdSize(),
		.wrReq(), .wrSel(), .wrSize(), .wrData(), .pcLoad(), .pcNext(), .aluFlagEn(),
		.aluBits(), .irqReq(), .irqLevel(), .irqAck(), .swiExec(), .swiNum());
	crf_core i_crf_core (.clk_sys(clk_sys), .reset_n(reset_n),
		.rdSel(i_crf_dp_model.rdSel), .rdSize(i_crf_dp_model.rdSize), .rdData(rdData),
		.wrReq(i_crf_dp_model.wrReq), .wrSel(i_crf_dp_model.wrSel),
		.wrSize(i_crf_dp_model.wrSize), .wrData(i_crf_dp_model.wrData),
		.pcLoad(i_crf_dp_model.pcLoad), .pcNext(i_crf_dp_model.pcNext),
		.aluFlagEn(i_crf_dp_model.aluFlagEn), .aluCarry(i_crf_dp_model.aluBits[3]),
		.aluZero(i_crf_dp_model.aluBits[2]), .aluSign(i_crf_dp_model.aluBits[1]),
		.aluOverflow(i_crf_dp_model.aluBits[0]), .irqReq(i_crf_dp_model.irqReq),
		.irqLevel(i_crf_dp_model.irqLevel), .irqAck(i_crf_dp_model.irqAck),
		.swiExec(i_crf_dp_model.swiExec), .swiNum(i_crf_dp_model.swiNum),
		.irqAccept(irqAccept), .stackPointer(stackPointer), .frameBase(frameBase),
		.staticBase(staticBase), .vectorTableBase(vectorTableBase),
		.programCounter(programCounter),
		.flagWord(flagWord), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// avalon master: hold request until waitrequest is sampled low
	task automatic avXfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(negedge clk_sys);
	endtask : avXfer

	task automatic avRd(input logic [5:0] a, input logic [31:0] exp);
		avXfer(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : avRd

	task automatic test_done;
		if (num_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		{reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{num_errors, checks, cycles} = '0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(negedge clk_sys);
		chk(flagWord, 32'h0);
		chk(programCounter, 32'h0);
		// thirteen registers, each at its own width; flag word last
		for (int i = 0; i < 13; i++) begin
			m = (i < 10) ? 32'h0000ffff : (i < 12) ? 32'h000fffff : 32'h000007ff;
			avXfer(1'b1, 6'(i * 4), 32'h55555555);
			avRd(6'(i * 4), 32'h55555555 & m);
		end
		chk(staticBase, 32'h5555);
		chk(vectorTableBase, 32'h55555);
		avXfer(1'b1, crf_pkg::OFS_FLG, 32'h0);
		avRd(6'h38, crf_pkg::UNMAPPED_RD);
		avXfer(1'b1, 6'h3c, 32'h1);
		avRd(6'h3c, crf_pkg::UNMAPPED_RD);
		// bank switching
		i_crf_dp_model.coreWr(crf_pkg::SEL_D0, crf_pkg::SZ_WORD, 32'h1234);
		avXfer(1'b1, crf_pkg::OFS_FLG, 32'h10);
		i_crf_dp_model.coreWr(crf_pkg::SEL_D0, crf_pkg::SZ_WORD, 32'habcd);
		avXfer(1'b1, crf_pkg::OFS_FB, 32'h2222);
		chk(frameBase, 32'h2222);
		avRd(crf_pkg::OFS_D0, 32'habcd);
		avXfer(1'b1, crf_pkg::OFS_FLG, 32'h0);
		avRd(crf_pkg::OFS_D0, 32'h1234);
		chk(frameBase, 32'h5555);
		// byte and pair views
		i_crf_dp_model.coreWr(crf_pkg::SEL_D0, crf_pkg::SZ_PAIR, 32'h89ab1234);
		i_crf_dp_model.coreRd(crf_pkg::SEL_D0, crf_pkg::SZ_LOW, q);
		chk(q, 32'h34);
		i_crf_dp_model.coreRd(crf_pkg::SEL_D0, crf_pkg::SZ_HIGH, q);
		chk(q, 32'h12);
		avRd(crf_pkg::OFS_D2, 32'h89ab);
		i_crf_dp_model.coreWr(crf_pkg::SEL_D0, crf_pkg::SZ_HIGH, 32'h77);
		avRd(crf_pkg::OFS_D0, 32'h7734);
		i_crf_dp_model.coreWr(crf_pkg::SEL_D1, crf_pkg::SZ_PAIR, 32'hcafe0bad);
		avRd(crf_pkg::OFS_D3, 32'hcafe);
		i_crf_dp_model.coreRd(crf_pkg::SEL_D1, crf_pkg::SZ_LOW, q);
		chk(q, 32'had);
		i_crf_dp_model.coreWr(crf_pkg::SEL_A0, crf_pkg::SZ_PAIR, 32'h43218765);
		avRd(crf_pkg::OFS_A1, 32'h4321);
		i_crf_dp_model.coreRd(crf_pkg::SEL_A0, crf_pkg::SZ_PAIR, q);
		chk(q, 32'h43218765);
		// stack select, acknowledge and software interrupts
		avXfer(1'b1, crf_pkg::OFS_ISP, 32'h1111);
		avXfer(1'b1, crf_pkg::OFS_USP, 32'h2222);
		chk(stackPointer, 32'h1111);
		avXfer(1'b1, crf_pkg::OFS_FLG, 32'hc0);
		chk(stackPointer, 32'h2222);
		i_crf_dp_model.strobe(2, 20'h0);
		chk(stackPointer, 32'h1111);
		chk(flagWord, 32'h0);
		avXfer(1'b1, crf_pkg::OFS_FLG, 32'h80);
		i_crf_dp_model.strobe(3, 20'd32);
		chk(stackPointer, 32'h2222);
		i_crf_dp_model.strobe(3, 20'd31);
		chk(stackPointer, 32'h1111);
		i_crf_dp_model.coreWr(crf_pkg::SEL_SP, crf_pkg::SZ_WORD, 32'h3333);
		chk(stackPointer, 32'h3333);
		// priority level and enable gate
		avXfer(1'b1, crf_pkg::OFS_FLG, 32'h340);
		i_crf_dp_model.irqSet(1'b1, 3'h3);
		chk(irqAccept, 32'h0);
		i_crf_dp_model.irqSet(1'b1, 3'h4);
		chk(irqAccept, 32'h1);
		avXfer(1'b1, crf_pkg::OFS_FLG, 32'h300);
		chk(irqAccept, 32'h0);
		i_crf_dp_model.irqSet(1'b0, 3'h0);
		// alu flags and program counter
		avXfer(1'b1, crf_pkg::OFS_FLG, 32'h0);
		i_crf_dp_model.strobe(1, 20'ha);
		chk(flagWord, 32'h009);
		i_crf_dp_model.strobe(1, 20'h5);
		chk(flagWord, 32'h024);
		i_crf_dp_model.strobe(0, 20'habcde);
		avRd(crf_pkg::OFS_PC, 32'habcde);
		test_done();
	end
endmodule : crf_core_tb
